// ===== design/msq_top.sv
// Four-channel sequencer, power-good flags, clock select and phase drive with AXI4-Lite registers
`timescale 1ns/1ps
module msq_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [msq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [msq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sequence command and channel enables
  input wire logic sequence_command,
  input wire logic sequence_command_open,
  input wire logic [3:0] channel_enable,
  // Per-channel comparators on the output sense
  input wire logic [3:0] sense_above_turn_on,
  input wire logic [3:0] sense_below_turn_off,
  input wire logic [3:0] sense_above_undervoltage_good,
  input wire logic [3:0] sense_above_undervoltage_fault,
  input wire logic [3:0] sense_above_overvoltage_fault,
  input wire logic [3:0] sense_above_overvoltage_good,
  input wire logic [3:0] loop_compensation_node_clamped,
  // Global faults
  input wire logic supply_uvlo,
  input wire logic power_stage_supply_uvlo,
  input wire logic thermal_shutdown,
  // Clocking
  input wire logic frequency_set_resistor_present,
  input wire logic sync_clock,
  // Channel control
  output logic [3:0] channel_run,
  output logic [3:0] soft_start_discharge,
  output logic [3:0] switch_node_idle,
  output logic [3:0] switch_node_pulse,
  output logic clock_external,
  // Power-good flags, open drain
  output logic [3:0] power_good_flag_o,
  output logic [3:0] power_good_flag_oe
);
  msq_pkg::msq_state_e state_q;
  logic [3:0] set_q;
  logic [3:0] seq_on_q;
  logic [1:0] ptr_q;
  logic cmd_q;
  logic global_fault;
  logic seq_rise;
  logic seq_fall;
  logic [2:0] first_up;
  logic [2:0] first_dn;
  logic [2:0] next_up;
  logic [2:0] next_dn;
  logic [3:0] run_d;
  logic [msq_pkg::PER_W-1:0] period_q;
  logic tick;
  logic [1:0] idx;
  logic ext_mode;
  logic [3:0] pull_low;

  // Pick the first set bit at or above from, or at or below from
  function automatic logic [2:0] pick(input logic [3:0] m, input int from, input logic up);
    logic [2:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (up) begin
        if (!r[2] && m[i] && (i >= from)) begin
          r = {1'b1, 2'(i)};
        end
      end else if (!r[2] && m[3-i] && ((3 - i) <= from)) begin
        r = {1'b1, 2'(3 - i)};
      end
    end
    return r;
  endfunction : pick

  assign global_fault = supply_uvlo | power_stage_supply_uvlo | thermal_shutdown;
  // Edges only count while the command pin is driven
  assign seq_rise = sequence_command & ~cmd_q & ~sequence_command_open;
  assign seq_fall = ~sequence_command & cmd_q & ~sequence_command_open;
  // Enables are sampled at the command edge for the sequence order; channel run still drops on a late clear
  assign first_up = pick(channel_enable, 0, 1'b1);
  assign first_dn = pick(channel_enable, 3, 1'b0);
  assign next_up = pick(set_q, int'(ptr_q) + 1, 1'b1);
  assign next_dn = pick(set_q, int'(ptr_q) - 1, 1'b0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= sequence_command & ~sequence_command_open;
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= msq_pkg::MSQ_IDLE;
      set_q <= '0;
      seq_on_q <= '0;
      ptr_q <= '0;
    end else if (global_fault) begin
      state_q <= msq_pkg::MSQ_FAULT;
      seq_on_q <= '0;
    end else if (seq_rise || (state_q == msq_pkg::MSQ_FAULT && cmd_q)) begin
      set_q <= channel_enable;
      seq_on_q <= '0;
      ptr_q <= first_up[1:0];
      if (first_up[2]) begin
        seq_on_q[first_up[1:0]] <= 1'b1;
        state_q <= msq_pkg::MSQ_UP;
      end else begin
        state_q <= msq_pkg::MSQ_IDLE;
      end
    end else if (seq_fall) begin
      set_q <= channel_enable;
      ptr_q <= first_dn[1:0];
      if (first_dn[2]) begin
        seq_on_q[first_dn[1:0]] <= 1'b0;
        state_q <= msq_pkg::MSQ_DOWN;
      end else begin
        seq_on_q <= '0;
        state_q <= msq_pkg::MSQ_IDLE;
      end
    end else begin
      unique case (state_q)
        msq_pkg::MSQ_IDLE: begin
          state_q <= msq_pkg::MSQ_IDLE;
        end
        msq_pkg::MSQ_UP: begin
          if (sense_above_turn_on[ptr_q]) begin
            if (next_up[2]) begin
              ptr_q <= next_up[1:0];
              seq_on_q[next_up[1:0]] <= 1'b1;
            end else begin
              state_q <= msq_pkg::MSQ_IDLE;
            end
          end
        end
        msq_pkg::MSQ_DOWN: begin
          if (sense_below_turn_off[ptr_q]) begin
            if (next_dn[2]) begin
              ptr_q <= next_dn[1:0];
              seq_on_q[next_dn[1:0]] <= 1'b0;
            end else begin
              seq_on_q <= '0;
              state_q <= msq_pkg::MSQ_IDLE;
            end
          end
        end
        msq_pkg::MSQ_FAULT: begin
          state_q <= msq_pkg::MSQ_IDLE;
        end
        default: begin
          state_q <= msq_pkg::MSQ_IDLE;
        end
      endcase
    end
  end

  // Channel run: the clamp drops run so soft start begins again on release
  always_comb begin
    for (int i = 0; i < msq_pkg::NCH; i++) begin
      run_d[i] = ~global_fault & channel_enable[i] & ~loop_compensation_node_clamped[i]
        & (sequence_command_open | seq_on_q[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_run <= '0;
      soft_start_discharge <= '1;
      switch_node_idle <= '1;
    end else begin
      channel_run <= run_d;
      soft_start_discharge <= ~run_d;
      switch_node_idle <= ~run_d;
    end
  end

  // Clock source and quarter ticks
  msq_clksel #(
    .QW(msq_pkg::PER_W)
  ) u_clksel (
    .aclk(aclk),
    .aresetn(aresetn),
    .sync_in(sync_clock),
    .qlen(period_q >> msq_pkg::SYNC_RATIO_LOG2),
    .tick_q(tick),
    .idx_q(idx),
    .ext_q(ext_mode)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_external <= 1'b0;
    end else begin
      clock_external <= ext_mode;
    end
  end

  // Per-channel phase drive and power-good flag
  genvar g;
  generate
    for (g = 0; g < msq_pkg::NCH; g++) begin : g_ch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          switch_node_pulse[g] <= 1'b0;
        end else begin
          // No resistor, no switching in either clock mode
          switch_node_pulse[g] <= run_d[g] & frequency_set_resistor_present & tick
            & (idx == msq_pkg::PHASE_Q[2*g +: 2]);
        end
      end

      msq_pgood u_pgood (
        .aclk(aclk),
        .aresetn(aresetn),
        .above_undervoltage_good(sense_above_undervoltage_good[g]),
        .above_undervoltage_fault(sense_above_undervoltage_fault[g]),
        .above_overvoltage_fault(sense_above_overvoltage_fault[g]),
        .above_overvoltage_good(sense_above_overvoltage_good[g]),
        .halt(~run_d[g]),
        .pull_low_q(pull_low[g])
      );

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          power_good_flag_o[g] <= 1'b0;
        end else begin
          power_good_flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign power_good_flag_oe = pull_low;

  // AXI4-Lite write side: address and data taken in either order
  logic aw_held_q;
  logic w_held_q;
  logic [msq_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= msq_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == msq_pkg::REG_PERIOD || aw_addr_q == msq_pkg::REG_STATUS)
          ? msq_pkg::RESP_OKAY : msq_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Period register, clamped so the rate stays inside its legal range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= msq_pkg::PER_RST;
    end else if (aw_held_q && w_held_q && !s_axi_bvalid && aw_addr_q == msq_pkg::REG_PERIOD
                 && w_strb_q[0]) begin
      if (w_data_q[msq_pkg::PER_W-1:0] < msq_pkg::PER_MIN) begin
        period_q <= msq_pkg::PER_MIN;
      end else if (w_data_q[msq_pkg::PER_W-1:0] > msq_pkg::PER_MAX) begin
        period_q <= msq_pkg::PER_MAX;
      end else begin
        period_q <= w_data_q[msq_pkg::PER_W-1:0];
      end
    end
  end

  // AXI4-Lite read side
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[msq_pkg::ST_RUN_LSB +: 4] = channel_run;
    status_word[msq_pkg::ST_PG_LSB +: 4] = ~pull_low;
    status_word[msq_pkg::ST_EXT] = clock_external;
    status_word[msq_pkg::ST_STATE_LSB +: 4] = state_q;
    status_word[msq_pkg::ST_RES] = frequency_set_resistor_present;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= msq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= msq_pkg::RESP_OKAY;
      if (s_axi_araddr == msq_pkg::REG_PERIOD) begin
        s_axi_rdata <= {{(32 - msq_pkg::PER_W){1'b0}}, period_q};
      end else if (s_axi_araddr == msq_pkg::REG_STATUS) begin
        s_axi_rdata <= status_word;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= msq_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : msq_top

// ===== pkg/msq_pkg.sv
// Shared constants for the four-channel sequencer, power-good and clock select block
package msq_pkg;
  localparam int NCH = 4;
  localparam int ADDR_W = 8;
  localparam int PER_W = 8;
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status field positions
  localparam int ST_RUN_LSB = 0;
  localparam int ST_PG_LSB = 4;
  localparam int ST_EXT = 8;
  localparam int ST_STATE_LSB = 9;
  localparam int ST_RES = 13;
  // Switching rate, in cycles of the 10 MHz bus clock
  localparam int CLK_HZ = 10_000_000;
  localparam int FSW_MIN_HZ = 100_000;
  localparam int FSW_MAX_HZ = 1_000_000;
  localparam int FSW_RST_HZ = 500_000;
  localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_HZ / FSW_MIN_HZ);
  localparam logic [PER_W-1:0] PER_MIN = PER_W'((CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ);
  localparam logic [PER_W-1:0] PER_RST = PER_W'(CLK_HZ / FSW_RST_HZ);
  // Sync clock runs at four times the switching rate
  localparam int SYNC_RATIO_LOG2 = 2;
  localparam int LOSS_PERIODS_LOG2 = 1;
  // Phase quarter of each switch channel: 0, 90, 270, 180 degrees
  localparam logic [2*NCH-1:0] PHASE_Q = {2'h2, 2'h3, 2'h1, 2'h0};
  typedef enum logic [3:0] {
    MSQ_IDLE = 4'h1,
    MSQ_UP = 4'h2,
    MSQ_DOWN = 4'h4,
    MSQ_FAULT = 4'h8
  } msq_state_e;
endpackage : msq_pkg

// ===== design/msq_pgood.sv
// Power-good flag of one channel with undervoltage and overvoltage hysteresis
`timescale 1ns/1ps
module msq_pgood (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator results of the sensed output
  input wire logic above_undervoltage_good,
  input wire logic above_undervoltage_fault,
  input wire logic above_overvoltage_fault,
  input wire logic above_overvoltage_good,
  input wire logic halt,
  // Open-drain pull, high while the flag is low
  output logic pull_low_q
);
  logic uv_ok_q;
  logic ov_ok_q;
  logic uv_ok_d;
  logic ov_ok_d;

  always_comb begin
    uv_ok_d = uv_ok_q;
    if (halt) begin
      uv_ok_d = 1'b0;
    end else if (above_undervoltage_good) begin
      uv_ok_d = 1'b1;
    end else if (!above_undervoltage_fault) begin
      uv_ok_d = 1'b0;
    end
    ov_ok_d = ov_ok_q;
    if (above_overvoltage_fault) begin
      ov_ok_d = 1'b0;
    end else if (!above_overvoltage_good) begin
      ov_ok_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_ok_q <= 1'b0;
      ov_ok_q <= 1'b1;
      pull_low_q <= 1'b1;
    end else begin
      uv_ok_q <= uv_ok_d;
      ov_ok_q <= ov_ok_d;
      pull_low_q <= halt | ~(uv_ok_d & ov_ok_d);
    end
  end
endmodule : msq_pgood

// ===== design/msq_clksel.sv
// Internal oscillator, sync clock detector and quarter-period phase ticks
`timescale 1ns/1ps
module msq_clksel #(
  parameter int QW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sync input and internal quarter length in cycles
  input wire logic sync_in,
  input wire logic [QW-1:0] qlen,
  // Quarter ticks and mode
  output logic tick_q,
  output logic [1:0] idx_q,
  output logic ext_q
);
  logic [QW-1:0] icnt_q;
  logic sync_d_q;
  logic seen_q;
  logic [QW+1:0] gap_q;
  logic [QW+1:0] per_q;
  logic srise;
  logic itick;
  logic lost;

  assign srise = sync_in & ~sync_d_q;
  assign itick = icnt_q >= (qlen - QW'(1));
  // Loss after two sync periods without an edge
  assign lost = {1'b0, gap_q} >= {per_q, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icnt_q <= '0;
      sync_d_q <= 1'b0;
    end else begin
      icnt_q <= itick ? '0 : icnt_q + QW'(1);
      sync_d_q <= sync_in;
    end
  end

  // Sync period measured on every edge so it is valid at switchover
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= '0;
      per_q <= '0;
      seen_q <= 1'b0;
    end else begin
      if (srise) begin
        gap_q <= '0;
        per_q <= gap_q + (QW+2)'(1);
      end else if (~&gap_q) begin
        gap_q <= gap_q + (QW+2)'(1);
      end
      if (itick) begin
        seen_q <= srise;
      end else if (srise) begin
        seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= 1'b0;
    end else if (!ext_q && itick && seen_q) begin
      ext_q <= 1'b1;
    end else if (ext_q && lost) begin
      ext_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
      idx_q <= '0;
    end else begin
      tick_q <= ext_q ? srise : itick;
      if (ext_q ? srise : itick) begin
        idx_q <= idx_q + 2'h1;
      end
    end
  end
endmodule : msq_clksel

// ===== sim/msq_props.sv
// Checker on the sequencer, power-good and clock select ports
`timescale 1ns/1ps
module msq_props (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Stimulus seen at the block
  input logic sequence_command,
  input logic sequence_command_open,
  input logic [3:0] channel_enable,
  input logic [3:0] sense_above_undervoltage_good,
  input logic [3:0] sense_above_undervoltage_fault,
  input logic [3:0] sense_above_overvoltage_fault,
  input logic [3:0] sense_above_overvoltage_good,
  input logic [3:0] loop_compensation_node_clamped,
  input logic supply_uvlo,
  input logic power_stage_supply_uvlo,
  input logic thermal_shutdown,
  input logic frequency_set_resistor_present,
  // Block outputs
  input logic [3:0] channel_run,
  input logic [3:0] switch_node_idle,
  input logic [3:0] switch_node_pulse,
  input logic [3:0] power_good_flag_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic gflt;
  logic [3:0] uvg, uvf, ovf, ovg, inr, band;
  assign gflt = supply_uvlo | power_stage_supply_uvlo | thermal_shutdown;
  assign uvg = sense_above_undervoltage_good;
  assign uvf = sense_above_undervoltage_fault;
  assign ovf = sense_above_overvoltage_fault;
  assign ovg = sense_above_overvoltage_good;
  assign inr = uvg & uvf & ~ovf & ~ovg;
  assign band = uvf & ~ovf & (~uvg | ovg);
  sequence s_up_cmd;
    $rose(sequence_command) && !sequence_command_open && channel_enable == 4'hf && !gflt && channel_run == 4'h0;
  endsequence
  sequence s_first_on;
    ##[1:3] channel_run == 4'h1;
  endsequence
  sequence s_down_cmd;
    $fell(sequence_command) && !sequence_command_open && channel_enable == 4'hf && channel_run == 4'hf;
  endsequence
  sequence s_top_off;
    ##[1:3] channel_run == 4'h7;
  endsequence
  seq_up_a: assert property (s_up_cmd |-> s_first_on) else $error("first channel not started alone");
  seq_down_a: assert property (s_down_cmd |-> s_top_off) else $error("top channel not stopped first");
  open_follow_a: assert property ($past(aresetn) && $past(sequence_command_open && !gflt &&
    loop_compensation_node_clamped == 4'h0) |-> channel_run == $past(channel_enable))
    else $error("open command: run does not follow enables");
  fault_off_a: assert property (gflt |=> channel_run == 4'h0 && switch_node_idle == 4'hf &&
    power_good_flag_oe == 4'hf) else $error("global fault left a channel on");
  clamp_off_a: assert property ((loop_compensation_node_clamped != 4'h0) |=>
    (channel_run & $past(loop_compensation_node_clamped)) == 4'h0) else $error("clamped channel still runs");
  pg_halt_a: assert property ((~channel_run & ~power_good_flag_oe) == 4'h0) else $error("good flag while halted");
  pg_good_a: assert property ($past(aresetn) |->
    (channel_run & $past(inr) & power_good_flag_oe) == 4'h0) else $error("flag low inside window");
  pg_uv_a: assert property ($past(aresetn) |-> ($past(~uvf) & ~power_good_flag_oe) == 4'h0)
    else $error("flag good below undervoltage fault");
  pg_ov_a: assert property ($past(aresetn) |-> ($past(ovf) & ~power_good_flag_oe) == 4'h0)
    else $error("flag good above overvoltage fault");
  pg_hold_a: assert property ((channel_run & $past(channel_run & band) &
    (power_good_flag_oe ^ $past(power_good_flag_oe))) == 4'h0) else $error("flag moved inside a band");
  phase_once_a: assert property ($onehot0(switch_node_pulse)) else $error("two phases pulsed together");
  no_resistor_a: assert property (!frequency_set_resistor_present [*3] |-> switch_node_pulse == 4'h0)
    else $error("switching without resistor");
endmodule : msq_props
bind msq_top msq_props u_props (.aclk, .aresetn, .sequence_command, .sequence_command_open, .channel_enable,
  .sense_above_undervoltage_good, .sense_above_undervoltage_fault, .sense_above_overvoltage_fault,
  .sense_above_overvoltage_good, .loop_compensation_node_clamped, .supply_uvlo, .power_stage_supply_uvlo,
  .thermal_shutdown, .frequency_set_resistor_present, .channel_run, .switch_node_idle, .switch_node_pulse,
  .power_good_flag_oe);

// ===== sim/msq_host.sv
// Far side model: sync clock source and output ramps seen by the sense comparators
`timescale 1ns/1ps
module msq_host #(
  parameter int HALF = 5,
  parameter int LAG = 2
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Control
  input logic sync_on,
  input logic [3:0] channel_run,
  // Toward the block
  output logic sync_clock,
  output logic [3:0] sense_above_turn_on,
  output logic [3:0] sense_below_turn_off
);
  int cnt_q;
  logic [3:0] ramp_q [LAG];
  always_ff @(posedge aclk) begin
    if (!aresetn || !sync_on) begin
      cnt_q <= 0;
      sync_clock <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      sync_clock <= ~sync_clock;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  always_ff @(posedge aclk) begin
    ramp_q[0] <= aresetn ? channel_run : 4'h0;
    for (int i = 1; i < LAG; i++) ramp_q[i] <= ramp_q[i-1];
  end
  assign sense_above_turn_on = ramp_q[LAG-1];
  assign sense_below_turn_off = ~ramp_q[LAG-1];
endmodule : msq_host

// ===== sim/tb_top.sv
// Self-checking bench for the sequencer, power-good and clock select block
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clock_external, sync_on, sync_clock;
  logic [msq_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, channel_enable, uvg, uvf, ovf, ovg, clamp, turn_on, turn_off;
  logic [3:0] channel_run, discharge, idle, pulse, pg_o, pg_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] flt;
  logic sequence_command, sequence_command_open, frequency_set_resistor_present;
  int num_errors, checks;
  msq_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sequence_command,
    .sequence_command_open, .channel_enable, .sense_above_turn_on(turn_on), .sense_below_turn_off(turn_off),
    .sense_above_undervoltage_good(uvg), .sense_above_undervoltage_fault(uvf),
    .sense_above_overvoltage_fault(ovf), .sense_above_overvoltage_good(ovg),
    .loop_compensation_node_clamped(clamp), .supply_uvlo(flt[0]), .power_stage_supply_uvlo(flt[1]),
    .thermal_shutdown(flt[2]), .frequency_set_resistor_present, .sync_clock, .channel_run,
    .soft_start_discharge(discharge), .switch_node_idle(idle), .switch_node_pulse(pulse), .clock_external,
    .power_good_flag_o(pg_o), .power_good_flag_oe(pg_oe));
  msq_host host (.aclk, .aresetn, .sync_on, .channel_run, .sync_clock, .sense_above_turn_on(turn_on),
    .sense_below_turn_off(turn_off));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d errors", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("MISMATCH at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask : bound
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    bound(n, 50);
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    bound(n, 50);
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, ed);
  endtask : rdc
  task automatic regs();
    rdc(msq_pkg::REG_PERIOD, 32'(msq_pkg::PER_RST), msq_pkg::RESP_OKAY);
    wr(msq_pkg::REG_PERIOD, 32'h5, 4'hf, msq_pkg::RESP_OKAY);
    rdc(msq_pkg::REG_PERIOD, 32'(msq_pkg::PER_MIN), msq_pkg::RESP_OKAY);
    wr(msq_pkg::REG_PERIOD, 32'hc8, 4'hf, msq_pkg::RESP_OKAY);
    rdc(msq_pkg::REG_PERIOD, 32'(msq_pkg::PER_MAX), msq_pkg::RESP_OKAY);
    wr(msq_pkg::REG_PERIOD, 32'h28, 4'h0, msq_pkg::RESP_OKAY);
    rdc(msq_pkg::REG_PERIOD, 32'(msq_pkg::PER_MAX), msq_pkg::RESP_OKAY);
    wr(msq_pkg::REG_PERIOD, 32'h28, 4'hf, msq_pkg::RESP_OKAY);
    rdc(msq_pkg::REG_PERIOD, 32'h28, msq_pkg::RESP_OKAY);
    wr(msq_pkg::REG_STATUS, 32'h0, 4'hf, msq_pkg::RESP_OKAY);
    wr(8'h0c, 32'h0, 4'hf, msq_pkg::RESP_SLVERR);
    rdc(8'h0c, 32'h0, msq_pkg::RESP_SLVERR);
  endtask : regs
  task automatic seq_go(input logic [3:0] en, input logic up);
    logic [3:0] prev, want;
    int n;
    prev = channel_run;
    for (n = 0; n < 300 && channel_run !== (up ? en : 4'h0); n++) begin
      @(posedge aclk);
      if (channel_run !== prev) begin
        want = up ? ((en & ~prev) & (~(en & ~prev) + 4'h1)) : 4'h0;
        for (int i = 0; i < 4; i++) if (!up && prev[i]) want = 4'h1 << i;
        chk(channel_run ^ prev, want);
        prev = channel_run;
      end
    end
    bound(n, 300);
    chk(channel_run, up ? en : 4'h0);
  endtask : seq_go
  task automatic seq_cases();
    logic [3:0] tbl [4] = '{4'hf, 4'hd, 4'h6, 4'h9};
    foreach (tbl[i]) begin
      channel_enable <= tbl[i];
      cyc(3);
      sequence_command <= 1'b1;
      seq_go(tbl[i], 1'b1);
      sequence_command <= 1'b0;
      seq_go(tbl[i], 1'b0);
    end
  endtask : seq_cases
  task automatic pg_steps();
    logic [4:0] tbl [9] = '{5'h18, 5'h08, 5'h01, 5'h09, 5'h18, 5'h1c, 5'h1f, 5'h1d, 5'h18};
    foreach (tbl[i]) begin
      uvg <= {4{tbl[i][4]}};
      uvf <= {4{tbl[i][3]}};
      ovg <= {4{tbl[i][2]}};
      ovf <= {4{tbl[i][1]}};
      cyc(3);
      chk(pg_oe, {4{tbl[i][0]}});
    end
    chk(pg_o, 4'h0);
  endtask : pg_steps
  task automatic clamp_case();
    int n;
    clamp <= 4'h2;
    cyc(3);
    chk({channel_run, pg_oe[1], discharge[1]}, 6'h37);
    clamp <= 4'h0;
    for (n = 0; n < 40 && channel_run !== 4'hf; n++) @(posedge aclk);
    bound(n, 40);
    chk(channel_run, 4'hf);
  endtask : clamp_case
  task automatic phase(input int p);
    int n, first [4];
    for (n = 0; n < 300 && pulse[0] !== 1'b1; n++) @(posedge aclk);
    bound(n, 300);
    first = '{0, 0, 0, 0};
    for (n = 1; n <= p; n++) begin
      @(posedge aclk);
      foreach (first[c]) if (pulse[c] === 1'b1 && first[c] == 0) first[c] = n;
    end
    chk({8'(first[1]), 8'(first[3]), 8'(first[2]), 8'(first[0])}, {8'(p / 4), 8'(p / 2), 8'(3 * p / 4), 8'(p)});
  endtask : phase
  task automatic clocks();
    int n;
    phase(40);
    sync_on <= 1'b1;
    for (n = 0; n < 200 && clock_external !== 1'b1; n++) @(posedge aclk);
    chk(n <= 80, 1'b1);
    bound(n, 200);
    cyc(2);
    phase(40);
    sync_on <= 1'b0;
    for (n = 0; n < 200 && clock_external !== 1'b0; n++) @(posedge aclk);
    chk(n >= 8 && n <= 30, 1'b1);
    bound(n, 200);
    phase(40);
    frequency_set_resistor_present <= 1'b0;
    cyc(3);
    for (n = 0; n < 80 && pulse === 4'h0; n++) @(posedge aclk);
    chk(n, 80);
    frequency_set_resistor_present <= 1'b1;
  endtask : clocks
  task automatic faults();
    for (int i = 0; i < 3; i++) begin
      flt <= 3'(1 << i);
      cyc(4);
      chk({channel_run, idle, pg_oe}, 12'h0ff);
      flt <= 3'h0;
      seq_go(4'hf, 1'b1);
    end
  endtask : faults
  task automatic open_case();
    sequence_command_open <= 1'b1;
    channel_enable <= 4'h5;
    cyc(3);
    chk(channel_run, 4'h5);
    channel_enable <= 4'ha;
    cyc(3);
    chk(channel_run, 4'ha);
  endtask : open_case
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sequence_command, sequence_command_open} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, channel_enable, flt, sync_on} = '0;
    {uvg, uvf, ovf, ovg, clamp} = 20'h0;
    {s_axi_bready, s_axi_rready, frequency_set_resistor_present} = 3'h7;
    cyc(3);
    aresetn <= 1'b1;
    regs();
    seq_cases();
    channel_enable <= 4'hf;
    cyc(3);
    sequence_command <= 1'b1;
    seq_go(4'hf, 1'b1);
    pg_steps();
    clamp_case();
    clocks();
    faults();
    sequence_command <= 1'b0;
    seq_go(4'hf, 1'b0);
    open_case();
    end_of_test();
  end
endmodule : tb_top
